// *** rtl/asbx_alu.v ***
// arithmetic, shift and bit logic of the execution block
`timescale 1ns/100ps
`include "asbx_defines.vh"
module asbx_alu (
	input  wire [2:0] op_in,
	input  wire [7:0] w_in,
	input  wire [7:0] f_in,
	input  wire       c_in,
	input  wire [2:0] bit_in,
	output reg  [7:0] res_out,
	output reg        c_out,
	output reg        dc_out,
	output wire       z_out,
	output wire       bit_out
);
	wire       cin;
	wire [4:0] lo;
	wire [8:0] sum;

	assign cin = (op_in == `ASBX_OP_ADD_C_F) ? c_in : 1'b0;
	assign lo  = {1'b0, w_in[3:0]} + {1'b0, f_in[3:0]} + {4'h0, cin};
	assign sum = {1'b0, w_in} + {1'b0, f_in} + {8'h00, cin};
	// [RL9] zero flag
	assign z_out   = (res_out == 8'h00);
	assign bit_out = f_in[bit_in];

	always @* begin
		res_out = f_in;
		c_out   = c_in;
		dc_out  = 1'b0;
		case (op_in)
			// [RL1] [RL2] [RL9] sum with carries
			`ASBX_OP_ADD_W_F, `ASBX_OP_ADD_C_F: begin
				res_out = sum[7:0];
				c_out   = sum[8];
				dc_out  = lo[4];
			end
			// [RL3] sign kept, bit 0 out
			`ASBX_OP_ASR_F: begin
				res_out = {f_in[7], f_in[7:1]};
				c_out   = f_in[0];
			end
			// [RL4] one bit cleared
			`ASBX_OP_BIT_CLEAR: begin
				res_out = f_in & ~(8'h01 << bit_in);
			end
			default: begin
				res_out = f_in;
			end
		endcase
	end
endmodule // asbx_alu

// *** rtl/asbx_core.v ***
// execution datapath with apb register access
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "asbx_defines.vh"
module asbx_core #(
	parameter PCW = 15,
	parameter FAW = 7
) (
	input  wire           MCLK_IN,
	input  wire           NRST_IN,
	input  wire           PSEL_IN,
	input  wire           PENABLE_IN,
	input  wire           PWRITE_IN,
	input  wire [7:0]     PADDR_IN,
	input  wire [31:0]    PWDATA_IN,
	output reg  [31:0]    PRDATA_OUT,
	output wire           PREADY_OUT,
	output wire           PSLVERR_OUT,
	output wire [PCW-1:0] PC_OUT,
	output wire           FLUSH_OUT,
	output wire           BUSY_OUT
);
	localparam ST_IDLE  = 4'b0001;
	localparam ST_READ  = 4'b0010;
	localparam ST_EXEC  = 4'b0100;
	localparam ST_FLUSH = 4'b1000;

	reg  [3:0]     state_reg;
	reg  [3:0]     state_next;
	reg  [25:0]    cmd_reg;
	reg  [7:0]     w_reg;
	reg            c_reg;
	reg            dc_reg;
	reg            z_reg;
	reg  [PCW-1:0] pc_reg;
	reg  [PCW-1:0] pc_next;
	reg  [FAW-1:0] faddr_reg;
	reg            acc_wait_reg;
	reg  [31:0]    rd_mux;
	reg            hit;

	wire [7:0]     f_data;
	wire [7:0]     alu_res;
	wire           alu_c;
	wire           alu_dc;
	wire           alu_z;
	wire           alu_bit;
	wire [2:0]     op;
	wire           busy;
	wire           wr_go;
	wire           rd_go;
	wire           exec;
	wire           to_file;
	wire           to_w;
	wire           upd_cz;
	wire           upd_dc;
	wire           skip;
	wire           two_cyc;
	wire           mem_we;
	wire [FAW-1:0] mem_wa;
	wire [FAW-1:0] mem_ra;
	wire [7:0]     mem_wd;
	wire [PCW-1:0] pc_inc;
	wire [PCW-1:0] k_ext;

	// ==========================================================
	// apb slave
	assign busy  = ~state_reg[0];
	assign op    = cmd_reg[`ASBX_CMD_OP];
	// one wait state: read data settle, and no access while busy
	assign PREADY_OUT  = PSEL_IN & PENABLE_IN & acc_wait_reg;
	assign PSLVERR_OUT = PREADY_OUT & ~hit;
	assign wr_go = PREADY_OUT & PWRITE_IN & hit;
	assign rd_go = PSEL_IN & PENABLE_IN & ~acc_wait_reg & ~PWRITE_IN;

	always @* begin
		hit    = 1'b1;
		rd_mux = 32'h00000000;
		if (PADDR_IN == `ASBX_OFF_CMD) begin
			rd_mux[25:0] = cmd_reg;
		end else if (PADDR_IN == `ASBX_OFF_WREG) begin
			rd_mux[7:0] = w_reg;
		end else if (PADDR_IN == `ASBX_OFF_STATUS) begin
			rd_mux[`ASBX_ST_C]    = c_reg;
			rd_mux[`ASBX_ST_DC]   = dc_reg;
			rd_mux[`ASBX_ST_Z]    = z_reg;
			rd_mux[`ASBX_ST_BUSY] = busy;
		end else if (PADDR_IN == `ASBX_OFF_PC) begin
			rd_mux[PCW-1:0] = pc_reg;
		end else if (PADDR_IN == `ASBX_OFF_FADDR) begin
			rd_mux[FAW-1:0] = faddr_reg;
		end else if (PADDR_IN == `ASBX_OFF_FDATA) begin
			rd_mux[7:0] = f_data;
		end else begin
			hit = 1'b0;
		end
	end

	always @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			acc_wait_reg <= 1'b0;
			PRDATA_OUT   <= 32'h00000000;
		end else begin
			acc_wait_reg <= PSEL_IN & PENABLE_IN & ~acc_wait_reg & ~busy;
			if (rd_go) begin
				PRDATA_OUT <= rd_mux;
			end
		end
	end

	// ==========================================================
	// file memory and alu
	assign to_file = exec & ((op == `ASBX_OP_BIT_CLEAR) |
		(cmd_reg[`ASBX_CMD_DEST] & ((op == `ASBX_OP_ADD_W_F) |
		(op == `ASBX_OP_ADD_C_F) | (op == `ASBX_OP_ASR_F))));
	assign to_w = exec & ~cmd_reg[`ASBX_CMD_DEST] &
		((op == `ASBX_OP_ADD_W_F) | (op == `ASBX_OP_ADD_C_F) |
		(op == `ASBX_OP_ASR_F));
	assign mem_we = to_file |
		(wr_go & (PADDR_IN == `ASBX_OFF_FDATA));
	assign mem_wa = busy ? cmd_reg[`ASBX_CMD_F] : faddr_reg;
	assign mem_wd = busy ? alu_res : PWDATA_IN[7:0];
	// operand fetch only in the read cycle, bus address otherwise
	assign mem_ra = state_reg[1] ? cmd_reg[`ASBX_CMD_F] : faddr_reg;

	asbx_filemem #(
		.AW (FAW),
		.DW (8)
	) u_mem (
		.clk_in    (MCLK_IN),
		.rst_n_in  (NRST_IN),
		.we_in     (mem_we),
		.waddr_in  (mem_wa),
		.wdata_in  (mem_wd),
		.raddr_in  (mem_ra),
		.rdata_out (f_data)
	);

	asbx_alu u_alu (
		.op_in   (op),
		.w_in    (w_reg),
		.f_in    (f_data),
		.c_in    (c_reg),
		.bit_in  (cmd_reg[`ASBX_CMD_BIT]),
		.res_out (alu_res),
		.c_out   (alu_c),
		.dc_out  (alu_dc),
		.z_out   (alu_z),
		.bit_out (alu_bit)
	);

	// ==========================================================
	// sequencing and program counter
	assign exec   = state_reg[2];
	// [RL1] [RL2] [RL9] add ops touch all flags
	assign upd_dc = (op == `ASBX_OP_ADD_W_F) | (op == `ASBX_OP_ADD_C_F);
	// [RL3] shift updates C and Z only
	assign upd_cz = upd_dc | (op == `ASBX_OP_ASR_F);
	// [RL5] [RL6] skip decision
	assign skip = ((op == `ASBX_OP_SKIP_CLEAR) & ~alu_bit) |
		((op == `ASBX_OP_SKIP_SET) & alu_bit);
	// [RL8] second cycle on pc change or true test
	assign two_cyc = skip | (op == `ASBX_OP_BRANCH);
	assign pc_inc = pc_reg + {{(PCW-1){1'b0}}, 1'b1};
	assign k_ext = {{(PCW-9){cmd_reg[24]}}, cmd_reg[`ASBX_CMD_K]};

	always @* begin
		pc_next = pc_inc;
		if (op == `ASBX_OP_BRANCH) begin
			// [RL7] incremented pc plus signed offset
			pc_next = pc_inc + k_ext;
		end else if (skip) begin
			// [RL5] [RL6] discarded next instruction
			pc_next = pc_inc + {{(PCW-1){1'b0}}, 1'b1};
		end
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (wr_go & (PADDR_IN == `ASBX_OFF_CMD)) begin
					state_next = ST_READ;
				end
			end
			ST_READ: begin
				state_next = ST_EXEC;
			end
			ST_EXEC: begin
				// [RL8] extra no-operation cycle
				state_next = two_cyc ? ST_FLUSH : ST_IDLE;
			end
			ST_FLUSH: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state_reg <= ST_IDLE;
			cmd_reg   <= `ASBX_RST_CMD;
			w_reg     <= `ASBX_RST_W;
			c_reg     <= `ASBX_RST_FLAG;
			dc_reg    <= `ASBX_RST_FLAG;
			z_reg     <= `ASBX_RST_FLAG;
			pc_reg    <= {PCW{1'b0}};
			faddr_reg <= `ASBX_RST_FA;
		end else begin
			state_reg <= state_next;
			if (wr_go) begin
				if (PADDR_IN == `ASBX_OFF_CMD) begin
					cmd_reg <= PWDATA_IN[`ASBX_CMD_W:0];
				end else if (PADDR_IN == `ASBX_OFF_WREG) begin
					w_reg <= PWDATA_IN[7:0];
				end else if (PADDR_IN == `ASBX_OFF_STATUS) begin
					c_reg  <= PWDATA_IN[`ASBX_ST_C];
					dc_reg <= PWDATA_IN[`ASBX_ST_DC];
					z_reg  <= PWDATA_IN[`ASBX_ST_Z];
				end else if (PADDR_IN == `ASBX_OFF_PC) begin
					pc_reg <= PWDATA_IN[PCW-1:0];
				end else if (PADDR_IN == `ASBX_OFF_FADDR) begin
					faddr_reg <= PWDATA_IN[FAW-1:0];
				end
			end
			if (exec) begin
				pc_reg <= pc_next;
				// [RL1] [RL2] [RL3] result to W when d is 0
				if (to_w) begin
					w_reg <= alu_res;
				end
				// [RL9] flag update; bit ops and skips leave flags
				if (upd_cz) begin
					c_reg <= alu_c;
					z_reg <= alu_z;
				end
				if (upd_dc) begin
					dc_reg <= alu_dc;
				end
			end
		end
	end

	assign PC_OUT    = pc_reg;
	assign FLUSH_OUT = state_reg[3];
	assign BUSY_OUT  = busy;
endmodule // asbx_core

// *** rtl/asbx_defines.vh ***
// constants for the add/shift/bit/branch execution block
// Behaviour
// [RL1] add_w_to_file adds W and f, writes W (d=0) or f (d=1), sets C, DC, Z.
// [RL2] add_with_carry_file adds W, f and carry, writes by d, sets C, DC, Z.
// [RL3] arith_shift_right_file keeps bit 7, shifts right, bit 0 to C, sets Z.
// [RL4] bit_clear_file clears bit b (0..7) of f and leaves every flag alone.
// [RL5] test_skip_if_clear skips the next instruction when the bit is zero.
// [RL6] test_skip_if_set skips the next instruction when the bit is one.
// [RL7] relative_branch_op loads PC+1 plus a signed 9-bit offset, two cycles.
// [RL8] a PC change or a true test adds a second cycle run as a no-operation.
// [RL9] Z marks a zero result, C carry out of bit 7, DC carry out of bit 3.
`ifndef ASBX_DEFINES_VH
`define ASBX_DEFINES_VH

// ==========================================================
// register byte offsets
`define ASBX_OFF_CMD    8'h00
`define ASBX_OFF_WREG   8'h04
`define ASBX_OFF_STATUS 8'h08
`define ASBX_OFF_PC     8'h0c
`define ASBX_OFF_FADDR  8'h10
`define ASBX_OFF_FDATA  8'h14

// ==========================================================
// command word fields
`define ASBX_CMD_OP   2:0
`define ASBX_CMD_DEST 3
`define ASBX_CMD_BIT  6:4
`define ASBX_CMD_F    14:8
`define ASBX_CMD_K    24:16
`define ASBX_CMD_W    25

// ==========================================================
// operation codes
`define ASBX_OP_NOP        3'h0
`define ASBX_OP_ADD_W_F    3'h1
`define ASBX_OP_ADD_C_F    3'h2
`define ASBX_OP_ASR_F      3'h3
`define ASBX_OP_BIT_CLEAR  3'h4
`define ASBX_OP_SKIP_CLEAR 3'h5
`define ASBX_OP_SKIP_SET   3'h6
`define ASBX_OP_BRANCH     3'h7

// ==========================================================
// status bits and reset values
`define ASBX_ST_C    0
`define ASBX_ST_DC   1
`define ASBX_ST_Z    2
`define ASBX_ST_BUSY 8
`define ASBX_RST_W    8'h00
`define ASBX_RST_FLAG 1'b0
`define ASBX_RST_CMD  26'h0000000
`define ASBX_RST_FA   7'h00

`endif

// *** rtl/asbx_filemem.v ***
// file register memory with registered read data
`timescale 1ns/100ps
module asbx_filemem #(
	parameter AW = 7,
	parameter DW = 8
) (
	input  wire          clk_in,
	input  wire          rst_n_in,
	input  wire          we_in,
	input  wire [AW-1:0] waddr_in,
	input  wire [DW-1:0] wdata_in,
	input  wire [AW-1:0] raddr_in,
	output reg  [DW-1:0] rdata_out
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	// read data one edge after the address; a write to the same
	// word in that edge is passed through so no stale value shows
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= {DW{1'b0}};
		end else if (we_in && (waddr_in == raddr_in)) begin
			rdata_out <= wdata_in;
		end else begin
			rdata_out <= mem[raddr_in];
		end
	end
endmodule // asbx_filemem

// *** test/add_shift_bit_branch_exec_tb.sv ***
// self-checking bench for the execution block
`timescale 1ns/100ps
module add_shift_bit_branch_exec_tb;
// ==========================================================
// signals
logic        clk = 1'b0;
logic        rst_n = 1'b0;
logic        psel = 1'b0;
logic        pen = 1'b0;
logic        pwr = 1'b0;
logic [7:0]  padr = 8'h00;
logic [31:0] pwd = 32'h0;
logic [31:0] prd, q;
logic        prdy, perr, e, flush, busy;
logic [14:0] pc;
logic [14:0] bpc[4] = '{15'h0100, 15'h0001, 15'h0000, 15'h7fff};
logic [8:0]  bk[4] = '{9'h100, 9'h0ff, 9'h100, 9'h001};
logic [14:0] bex[4] = '{15'h0001, 15'h0101, 15'h7f01, 15'h0001};
int          error_cnt = 0;
int          checks_done = 0;
int          i;
always #25 clk = ~clk;
asbx_core dut_u (.MCLK_IN(clk), .NRST_IN(rst_n), .PSEL_IN(psel),
	.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd),
	.PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
	.PC_OUT(pc), .FLUSH_OUT(flush), .BUSY_OUT(busy));
// ==========================================================
// tasks
task chk(input logic [31:0] seen, input logic [31:0] exp);
	checks_done++;
	if (seen !== exp) begin
		error_cnt++;
		$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask
task results;
	$display("errors=%0d checks=%0d", error_cnt, checks_done);
	if (error_cnt == 0 && checks_done > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	int n;
	n = 0;
	@(posedge clk);
	psel <= 1'b1;
	pwr <= w;
	padr <= a;
	pwd <= d;
	@(posedge clk);
	pen <= 1'b1;
	@(posedge clk);
	while (prdy !== 1'b1 && n < 200) begin
		n++;
		@(posedge clk);
	end
	if (n == 200) error_cnt++;
	q = prd;
	e = perr;
	psel <= 1'b0;
	pen <= 1'b0;
endtask
task rd(input logic [7:0] a, input logic [31:0] exp);
	apb(1'b0, a, 32'h0);
	chk(q, exp);
endtask
// flush level two edges after a command is taken
task fl(input logic exp);
	repeat (2) @(posedge clk);
	#1;
	chk({31'h0, flush}, {31'h0, exp});
endtask
function logic [31:0] cmd(input logic [2:0] o, input logic d,
	input logic [2:0] b, input logic [8:0] k);
	cmd = {7'h0, k, 8'h05, 1'b0, b, d, o};
endfunction
// ==========================================================
// tests
initial begin
	repeat (2) @(posedge clk);
	rst_n <= 1'b1;
	apb(1'b1, 8'h04, 32'h8f);
	apb(1'b1, 8'h10, 32'h05);
	apb(1'b1, 8'h14, 32'h71);
	apb(1'b1, 8'h00, cmd(3'h1, 1'b1, 3'h0, 9'h0));
	rd(8'h14, 32'h00);
	rd(8'h08, 32'h07);
	apb(1'b1, 8'h00, cmd(3'h2, 1'b0, 3'h0, 9'h0));
	rd(8'h04, 32'h90);
	rd(8'h08, 32'h02);
	apb(1'b1, 8'h14, 32'h81);
	apb(1'b1, 8'h00, cmd(3'h3, 1'b1, 3'h0, 9'h0));
	rd(8'h14, 32'hc0);
	rd(8'h08, 32'h03);
	apb(1'b1, 8'h00, cmd(3'h4, 1'b0, 3'h7, 9'h0));
	rd(8'h14, 32'h40);
	rd(8'h08, 32'h03);
	for (i = 0; i < 4; i++) begin
		apb(1'b1, 8'h0c, 32'h10);
		apb(1'b1, 8'h00, cmd(3'h5 + i / 2, 1'b0, 3'(i % 2 * 6), 9'h0));
		fl(i == 0 || i == 3);
		rd(8'h0c, (i == 0 || i == 3) ? 32'h12 : 32'h11);
		rd(8'h08, 32'h03);
	end
	for (i = 0; i < 4; i++) begin
		apb(1'b1, 8'h0c, {17'h0, bpc[i]});
		apb(1'b1, 8'h00, cmd(3'h7, 1'b0, 3'h0, bk[i]));
		fl(1'b1);
		rd(8'h0c, {17'h0, bex[i]});
		chk({17'h0, pc}, {17'h0, bex[i]});
		rd(8'h08, 32'h03);
	end
	rd(8'h40, 32'h0);
	chk({31'h0, e}, 32'h1);
	results;
end
// hang guard
initial begin
	repeat (3000) @(posedge clk);
	error_cnt++;
	results;
end
endmodule // add_shift_bit_branch_exec_tb

// *** test/asbx_core_assertions.sv ***
// port checker for the execution block
`timescale 1ns/100ps
module asbx_core_chk #(parameter PCW = 15) (
	input wire           MCLK_IN,
	input wire           NRST_IN,
	input wire           PSEL_IN,
	input wire           PENABLE_IN,
	input wire           PWRITE_IN,
	input wire [7:0]     PADDR_IN,
	input wire [31:0]    PWDATA_IN,
	input wire [31:0]    PRDATA_OUT,
	input wire           PREADY_OUT,
	input wire           PSLVERR_OUT,
	input wire [PCW-1:0] PC_OUT,
	input wire           FLUSH_OUT,
	input wire           BUSY_OUT
);
// ==========================================================
// command decode
wire           tk = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN
	& (PADDR_IN == 8'h00);
wire [2:0]     op = PWDATA_IN[2:0];
wire           plain = tk & (op >= 3'h1) & (op <= 3'h4);
wire           skp = tk & ((op == 3'h5) | (op == 3'h6));
wire           relative_branch_op = tk & (op == 3'h7);
wire [PCW-1:0] kx = {{(PCW-9){PWDATA_IN[24]}}, PWDATA_IN[24:16]};
default clocking @(posedge MCLK_IN); endclocking
default disable iff (!NRST_IN);
// ==========================================================
// assertions
a_flush_busy: assert property (FLUSH_OUT |-> BUSY_OUT)
	else $error("flush outside busy");
a_flush_single: assert property (FLUSH_OUT |=> !FLUSH_OUT)
	else $error("flush longer than one cycle");
a_plain_timing: assert property (plain |=>
	(BUSY_OUT && !FLUSH_OUT) ##1 BUSY_OUT ##1 !BUSY_OUT)
	else $error("plain op timing wrong");
a_plain_pc: assert property (plain |=>
	##2 PC_OUT == $past(PC_OUT, 3) + 1'b1)
	else $error("plain op pc wrong");
a_skip_pc: assert property (skp |=> ##2
	PC_OUT == $past(PC_OUT, 3) + (FLUSH_OUT ? 2'd2 : 2'd1))
	else $error("skip pc wrong");
a_branch_flush: assert property (relative_branch_op |=>
	##2 (FLUSH_OUT && BUSY_OUT) ##1 !BUSY_OUT)
	else $error("branch flush missing");
a_branch_pc: assert property (relative_branch_op |=> ##2
	PC_OUT == $past(PC_OUT, 3) + 1'b1 + $past(kx, 3))
	else $error("branch target wrong");
a_busy_stall: assert property (BUSY_OUT |-> !PREADY_OUT)
	else $error("bus answered while busy");
endmodule // asbx_core_chk
bind asbx_core asbx_core_chk #(.PCW(PCW)) chk_u (.MCLK_IN(MCLK_IN),
	.NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
	.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .PC_OUT(PC_OUT), .FLUSH_OUT(FLUSH_OUT),
	.BUSY_OUT(BUSY_OUT));
